// *** hdl/adc_monitor_axi_intr_regs.sv ***
// AXI4-Lite register block of an ADC and sensor monitor: interrupt logic,
// soft reset and a 16-bit macro register port mapped onto the 32-bit bus.
// Assumes the macro register port runs on clk and answers with one ready pulse.
//
// Notes on behaviour
// - Enable bits 13:10, 3:1 gate sensor alarms.
// - Bit 5 gates conversion, bit 4 sequence.
// - Bit 8 overheat release, bit 9 alarm release.
// - Bit 7 debug write, bit 6 lock request.
// - Bit 0 gates factory overheat alarm.
// - Release events come from alarm falling edges.
// - Macro data sits in low sixteen bits.
// - Conversion results are left aligned at 15:6.
// - Read data carries debug wrote and lock bits.
// - Good fabric access clears debug wrote flag.
// - Fabric macro access fails while port locked.
// - Narrow macro access returns error response.
// - Parameter includes or omits interrupt logic.
// - Address 11 bits, data 32, strobes four.
// - Macro clock is bus clock; divider by software.
// - Other bus options expose clock and reset.
// - Writing 0xA at offset 0 soft resets.
// - Writing one toggles status bit; reset clears.
// - Bit 31 gate passes enabled interrupts.
// - Sources caught on rising edge, except inputs 8 and 9.
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_axi_intr_regs #(
    parameter bit interrupt_logic_present = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [10:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [10:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [13:0] alarm_sources,
    input wire logic debug_port_wrote,
    input wire logic debug_port_lock,
    output logic macro_clock,
    output logic macro_register_port_en,
    output logic macro_register_port_we,
    output logic [6:0] macro_register_port_addr,
    output logic [15:0] macro_register_port_wdata,
    input wire logic [15:0] macro_register_port_rdata,
    input wire logic macro_register_port_ready,
    output logic soft_reset,
    output logic interrupt
);

    // =====================================================================
    // State
    typedef enum logic [2:0] {IDLE, MACRO_WAIT, WRITE_RESP, READ_RESP} phase_type;

    typedef struct packed {
        phase_type phase;
        logic wr;
        logic [10:0] addr;
        logic [31:0] wdata;
        logic [13:0] src_sync1;
        logic [13:0] src_sync2;
        logic [13:0] src_prev;
        logic [1:0] lock_sync;
        logic [1:0] wrote_sync;
        logic wrote_prev;
        logic wrote_sticky;
        logic [13:0] enable;
        logic [13:0] status;
        logic gate;
        logic [1:0] resp;
        logic [31:0] rdata;
        logic soft_reset;
        logic irq;
        logic mreq;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    // True when the address falls in the macro register window.
    function automatic logic is_macro(input logic [10:0] a);
        is_macro = (a >= adc_monitor_pkg::MACRO_BASE_OFS) &&
                   (a <= adc_monitor_pkg::MACRO_END_OFS);
    endfunction

    // Macro register index from a byte address.
    function automatic logic [6:0] macro_index(input logic [10:0] a);
        macro_index = a[8:2];
    endfunction

    logic [13:0] rise;
    logic [13:0] release_ev;
    logic [13:0] events;
    logic [13:0] toggle;
    logic [31:0] local_rd;

    // =====================================================================
    // Macro clock is the bus clock in this bus option.
    assign macro_clock = clk;

    // Source edges: rising edges of every source except bits 8 and 9, which take locally made falling
    // edge events from the overheat and temperature alarms.
    always_comb
    begin
        rise = state_r.src_sync2 & ~state_r.src_prev;
        release_ev = '0;
        release_ev[adc_monitor_pkg::OVERHEAT_REL_BIT] =
            state_r.src_prev[adc_monitor_pkg::OVERHEAT_BIT] &
            ~state_r.src_sync2[adc_monitor_pkg::OVERHEAT_BIT];
        release_ev[adc_monitor_pkg::TEMP_REL_BIT] =
            state_r.src_prev[adc_monitor_pkg::TEMP_ALARM_BIT] &
            ~state_r.src_sync2[adc_monitor_pkg::TEMP_ALARM_BIT];
        // Bits 8 and 9 are set only by release events, never by an input rise.
        rise[adc_monitor_pkg::OVERHEAT_REL_BIT] = 1'b0;
        rise[adc_monitor_pkg::TEMP_REL_BIT] = 1'b0;
        events = (rise | release_ev) & adc_monitor_pkg::SRC_MASK;
    end

    // Local register read mux, decoded from the read address at the take so
    // that read data is valid in the first cycle in which rvalid stands.
    always_comb
    begin
        local_rd = '0;
        unique case (s_axi_araddr)
            adc_monitor_pkg::GLOBAL_GATE_OFS:
                local_rd[adc_monitor_pkg::GATE_BIT] = state_r.gate;
            adc_monitor_pkg::STATUS_OFS:
                local_rd[13:0] = state_r.status;
            adc_monitor_pkg::ENABLE_OFS:
                local_rd[13:0] = state_r.enable;
            default:
                local_rd = '0;
        endcase
    end

    // Next-state logic for the bus slave, the macro access and interrupts.
    always_comb
    begin
        state_nxt = state_r;
        toggle = '0;
        // Two-flop synchronisers; only the second stage feeds the edge
        // detectors, so a metastable first stage is never decoded.
        state_nxt.src_sync1 = alarm_sources;
        state_nxt.src_sync2 = state_r.src_sync1;
        state_nxt.src_prev = state_r.src_sync2;
        state_nxt.lock_sync = {state_r.lock_sync[0], debug_port_lock};
        state_nxt.wrote_sync = {state_r.wrote_sync[0], debug_port_wrote};
        state_nxt.wrote_prev = state_r.wrote_sync[1];
        // The port request is a one-cycle pulse.
        state_nxt.mreq = 1'b0;
        unique case (state_r.phase)
            IDLE:
            begin
                // Writes take priority over a read offered in the same idle cycle.
                if (s_axi_awvalid && s_axi_wvalid)
                begin
                    state_nxt.wr = 1'b1;
                    state_nxt.addr = s_axi_awaddr;
                    state_nxt.wdata = s_axi_wdata;
                    state_nxt.resp = adc_monitor_pkg::RESP_OKAY;
                    state_nxt.phase = WRITE_RESP;
                    // Narrow and locked macro writes are refused before the port.
                    if (is_macro(s_axi_awaddr))
                    begin
                        if (s_axi_wstrb != 4'hf)
                        begin
                            state_nxt.resp = adc_monitor_pkg::RESP_SLVERR;
                        end
                        else if (state_r.lock_sync[1])
                        begin
                            state_nxt.resp = adc_monitor_pkg::RESP_SLVERR;
                        end
                        else
                        begin
                            state_nxt.mreq = 1'b1;
                            state_nxt.phase = MACRO_WAIT;
                        end
                    end
                    else if (s_axi_awaddr == adc_monitor_pkg::SOFT_RESET_OFS)
                    begin
                        state_nxt.soft_reset =
                            (s_axi_wdata[3:0] == adc_monitor_pkg::SOFT_RESET_KEY);
                    end
                    else if (interrupt_logic_present &&
                             s_axi_awaddr == adc_monitor_pkg::GLOBAL_GATE_OFS)
                    begin
                        state_nxt.gate = s_axi_wdata[adc_monitor_pkg::GATE_BIT];
                    end
                    else if (interrupt_logic_present &&
                             s_axi_awaddr == adc_monitor_pkg::STATUS_OFS)
                    begin
                        toggle = s_axi_wdata[13:0];
                    end
                    else if (interrupt_logic_present &&
                             s_axi_awaddr == adc_monitor_pkg::ENABLE_OFS)
                    begin
                        state_nxt.enable = s_axi_wdata[13:0];
                    end
                end
                else if (s_axi_arvalid)
                begin
                    state_nxt.wr = 1'b0;
                    state_nxt.addr = s_axi_araddr;
                    state_nxt.resp = adc_monitor_pkg::RESP_OKAY;
                    state_nxt.rdata = local_rd;
                    state_nxt.phase = READ_RESP;
                    if (is_macro(s_axi_araddr))
                    begin
                        // A locked read returns only the two flags, with an error.
                        if (state_r.lock_sync[1])
                        begin
                            state_nxt.resp = adc_monitor_pkg::RESP_SLVERR;
                            state_nxt.rdata[adc_monitor_pkg::MACRO_WROTE_BIT] =
                                state_r.wrote_sticky;
                            state_nxt.rdata[adc_monitor_pkg::MACRO_LOCK_BIT] = 1'b1;
                        end
                        else
                        begin
                            state_nxt.mreq = 1'b1;
                            state_nxt.phase = MACRO_WAIT;
                        end
                    end
                end
            end
            MACRO_WAIT:
            begin
                // The answer clears the debug-write flag; its old value goes out
                // with the read data so software can tell a disturbed read.
                if (macro_register_port_ready)
                begin
                    state_nxt.wrote_sticky = 1'b0;
                    state_nxt.phase = state_r.wr ? WRITE_RESP : READ_RESP;
                    if (!state_r.wr)
                    begin
                        // Low half carries data; results sit left aligned at 15:6.
                        state_nxt.rdata = {14'h0000, state_r.lock_sync[1], state_r.wrote_sticky,
                                           macro_register_port_rdata};
                    end
                end
            end
            WRITE_RESP:
            begin
                // The response stands until the master takes it.
                if (s_axi_bready)
                begin
                    state_nxt.phase = IDLE;
                end
            end
            READ_RESP:
            begin
                // Read data was loaded at the take, or at the macro answer, and stands until rready.
                if (s_axi_rready)
                begin
                    state_nxt.phase = IDLE;
                end
            end
            default:
                state_nxt.phase = IDLE;
        endcase
        // A new debug-port write is flagged after the case, so that it wins
        // over a clear by a macro answer in the same cycle.
        if (state_r.wrote_sync[1] && !state_r.wrote_prev)
        begin
            state_nxt.wrote_sticky = 1'b1;
        end
        // Event set wins over a toggle that would clear the same bit.
        if (interrupt_logic_present)
        begin
            state_nxt.status = (state_r.status ^ toggle) | events;
        end
        else
        begin
            state_nxt.status = adc_monitor_pkg::STATUS_RESET;
        end
        // Interrupt is registered, one cycle behind status, enable and gate.
        state_nxt.irq = interrupt_logic_present && state_r.gate &&
                        |(state_r.status & state_r.enable);
        // Soft reset overrides a bus write to these registers in the same cycle.
        if (state_r.soft_reset)
        begin
            state_nxt.enable = adc_monitor_pkg::ENABLE_RESET;
            state_nxt.status = adc_monitor_pkg::STATUS_RESET;
            state_nxt.gate = 1'b0;
            state_nxt.soft_reset = 1'b0;
        end
    end

    // Registers all state; reset clears enables, status and the gate.
    // Sync stages clear to the pins' idle level, so no false edge follows reset.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r <= '0;
            state_r.phase <= IDLE;
            state_r.enable <= adc_monitor_pkg::ENABLE_RESET;
            state_r.status <= adc_monitor_pkg::STATUS_RESET;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // =====================================================================
    // Outputs.
    // Write and read ready are combinational; responses come from registers.
    assign s_axi_awready = (state_r.phase == IDLE) && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = (state_r.phase == IDLE) && !(s_axi_awvalid && s_axi_wvalid);
    assign s_axi_bvalid = (state_r.phase == WRITE_RESP);
    assign s_axi_bresp = state_r.resp;
    assign s_axi_rvalid = (state_r.phase == READ_RESP);
    assign s_axi_rresp = state_r.resp;
    assign s_axi_rdata = state_r.rdata;
    assign macro_register_port_en = state_r.mreq;
    assign macro_register_port_we = state_r.mreq && state_r.wr;
    assign macro_register_port_addr = macro_index(state_r.addr);
    assign macro_register_port_wdata = state_r.wdata[15:0];
    assign soft_reset = state_r.soft_reset;
    assign interrupt = state_r.irq;

endmodule

`default_nettype wire

// *** inc/adc_monitor_pkg.sv ***
// Package for the ADC monitor bus-side register block.
// Assumes a 32-bit AXI4-Lite slave with 11-bit byte addresses.
package adc_monitor_pkg;

    // =====================================================================
    // Bus geometry
    localparam int ADDR_W = 11;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // =====================================================================
    // Register byte offsets
    localparam logic [10:0] SOFT_RESET_OFS = 11'h000;
    localparam logic [10:0] GLOBAL_GATE_OFS = 11'h05c;
    localparam logic [10:0] STATUS_OFS = 11'h060;
    localparam logic [10:0] ENABLE_OFS = 11'h068;
    localparam logic [10:0] MACRO_BASE_OFS = 11'h200;
    localparam logic [10:0] MACRO_END_OFS = 11'h3fc;

    // =====================================================================
    // Field positions and values
    localparam logic [3:0] SOFT_RESET_KEY = 4'ha;
    localparam int GATE_BIT = 31;
    localparam int SRC_W = 14;
    localparam logic [13:0] SRC_MASK = 14'h3fff;
    localparam logic [13:0] ENABLE_RESET = 14'h0000;
    localparam logic [13:0] STATUS_RESET = 14'h0000;
    localparam int OVERHEAT_BIT = 0;
    localparam int TEMP_ALARM_BIT = 1;
    localparam int OVERHEAT_REL_BIT = 8;
    localparam int TEMP_REL_BIT = 9;
    localparam int MACRO_WROTE_BIT = 16;
    localparam int MACRO_LOCK_BIT = 17;
    localparam int RESULT_LSB = 6;

    // =====================================================================
    // Response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** sim/adc_monitor_monitor.sv ***
// Checker for the ADC monitor bus register block.
// Assumes one clock, clk, and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic [10:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [10:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic debug_port_lock,
    input wire logic macro_register_port_en,
    input wire logic macro_register_port_we,
    input wire logic [6:0] macro_register_port_addr,
    input wire logic [15:0] macro_register_port_wdata,
    input wire logic macro_register_port_ready,
    input wire logic soft_reset
);
    // ==========================================================
    // Helper terms
    logic aw_take;
    logic aw_macro;
    logic ar_macro;
    logic [2:0] lock_hi_r;
    logic [2:0] lock_lo_r;

    // Takes of writes and reads, and whether they hit the macro window.
    assign aw_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
    assign aw_macro = aw_take && (s_axi_awaddr[10:9] == 2'h1);
    assign ar_macro = s_axi_arvalid && s_axi_arready && (s_axi_araddr[10:9] == 2'h1);

    // Counts how long the lock has stood, so sync delay is ruled out.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            lock_hi_r <= 3'h0;
            lock_lo_r <= 3'h0;
        end
        else
        begin
            lock_hi_r <= !debug_port_lock ? 3'h0 : (lock_hi_r == 3'h4 ? 3'h4 : lock_hi_r + 3'h1);
            lock_lo_r <= debug_port_lock ? 3'h0 : (lock_lo_r == 3'h4 ? 3'h4 : lock_lo_r + 3'h1);
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_narrow_error: assert property (aw_macro && s_axi_wstrb != 4'hf |=> s_axi_bvalid &&
        s_axi_bresp == adc_monitor_pkg::RESP_SLVERR) else $error("narrow macro write not refused");
    a_narrow_no_port: assert property (aw_macro && s_axi_wstrb != 4'hf
        |=> !macro_register_port_en [*3]) else $error("narrow macro write reached port");
    a_locked_no_port: assert property ((aw_macro || ar_macro) && lock_hi_r == 3'h4
        |=> !macro_register_port_en [*3]) else $error("locked access reached port");
    a_macro_write: assert property (aw_macro && s_axi_wstrb == 4'hf && lock_lo_r == 3'h4
        |=> macro_register_port_en && macro_register_port_we
        && macro_register_port_wdata == $past(s_axi_wdata[15:0])
        && macro_register_port_addr == $past(s_axi_awaddr[8:2])) else $error("bad macro write");
    a_macro_read: assert property (ar_macro && lock_lo_r == 3'h4
        |=> macro_register_port_en && !macro_register_port_we
        && macro_register_port_addr == $past(s_axi_araddr[8:2])) else $error("bad macro read");
    a_ready_answer: assert property (macro_register_port_ready
        |=> s_axi_bvalid || s_axi_rvalid) else $error("macro answer not returned");
    a_soft_reset_pulse: assert property (aw_take && s_axi_awaddr == 11'h000 && s_axi_wstrb[0]
        && s_axi_wdata[3:0] == 4'ha |=> soft_reset ##1 !soft_reset) else $error("no soft reset");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write response dropped");

    c_narrow: cover property (aw_macro && s_axi_wstrb != 4'hf);
    c_locked: cover property (ar_macro && lock_hi_r == 3'h4);
    c_soft: cover property ($rose(soft_reset));
endmodule

bind adc_monitor_axi_intr_regs adc_monitor_monitor mon (.*);
`default_nettype wire

// *** sim/macro_register_model.sv ***
// Model of the 16-bit macro register file behind the register port.
// Assumes one request at a time; answers after a chosen number of cycles.
`timescale 1ns/1ps
`default_nettype none

module macro_register_model (
    input wire logic clk,
    input wire logic [1:0] delay,
    input wire logic macro_register_port_en,
    input wire logic macro_register_port_we,
    input wire logic [6:0] macro_register_port_addr,
    input wire logic [15:0] macro_register_port_wdata,
    output logic [15:0] macro_register_port_rdata,
    output logic macro_register_port_ready
);
    // ==========================================================
    // Register file and answer timing
    logic [15:0] mem [0:127];
    logic [6:0] addr_q;
    logic [1:0] wait_q;
    logic busy = 1'b0;

    initial
    begin
        macro_register_port_rdata = 16'h5a5a;
        macro_register_port_ready = 1'b0;
    end

    // Data toggles when idle so that stale read data is never mistaken.
    always @(posedge clk)
    begin
        macro_register_port_ready <= 1'b0;
        macro_register_port_rdata <= ~macro_register_port_rdata;
        if (macro_register_port_en)
        begin
            busy <= 1'b1;
            wait_q <= delay;
            addr_q <= macro_register_port_addr;
            if (macro_register_port_we)
                mem[macro_register_port_addr] <= macro_register_port_wdata;
        end
        else if (busy && wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
        else if (busy)
        begin
            busy <= 1'b0;
            macro_register_port_ready <= 1'b1;
            macro_register_port_rdata <= mem[addr_q];
        end
    end
endmodule
`default_nettype wire

// *** sim/adc_monitor_axi_intr_regs_bench.sv ***
// Self-checking bench for the ADC monitor bus register block.
// Assumes the package, the design, the checker and the macro model.
`timescale 1ns/1ps
`default_nettype none

module adc_monitor_axi_intr_regs_bench;
    // ==========================================================
    // Signals
    logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic debug_port_wrote, debug_port_lock, macro_clock, soft_reset, interrupt;
    logic macro_register_port_en, macro_register_port_we, macro_register_port_ready;
    logic [10:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, delay, resp;
    logic [13:0] alarm_sources;
    logic [6:0] macro_register_port_addr;
    logic [15:0] macro_register_port_wdata, macro_register_port_rdata;
    int fails, check_count, pulses;

    adc_monitor_axi_intr_regs dut (.*);
    macro_register_model model (.*);

    // Clock, and a count of soft reset pulses.
    always #2 clk = ~clk;
    always @(posedge clk)
        if (soft_reset === 1'b1) pulses <= pulses + 1;

    // ==========================================================
    // Bus tasks; each is entered just after a rising edge.
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic bus_write(input logic [10:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int n;
        logic ok;
        n = 0;
        resp = 2'bxx;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(negedge clk);
            ok = s_axi_awready && s_axi_wready;
            @(posedge clk);
        end while (!ok && ++n < 50);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do
        begin
            @(negedge clk);
            ok = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk);
        end while (!ok && ++n < 50);
        check({31'h0, ok}, 32'h1);
        check({30'h0, resp}, {30'h0, er});
    endtask

    task automatic bus_read(input logic [10:0] a, input logic [31:0] m, input logic [31:0] e,
                            input logic [1:0] er);
        int n;
        logic ok;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(negedge clk);
            ok = s_axi_arready;
            @(posedge clk);
        end while (!ok && ++n < 50);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(negedge clk);
            ok = s_axi_rvalid;
            @(posedge clk);
        end while (!ok && ++n < 50);
        s_axi_rready <= 1'b1;
        @(negedge clk);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
        check({31'h0, ok}, 32'h1);
        check(got & m, e);
        check({30'h0, resp}, {30'h0, er});
    endtask

    task automatic check_irq(input logic e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({31'h0, interrupt}, {31'h0, e});
        @(posedge clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_enables;
        bus_read(11'h068, 32'h3fff, 32'h0, 2'h0);
        bus_read(11'h060, 32'h3fff, 32'h0, 2'h0);
        bus_read(11'h05c, 32'h8000_0000, 32'h0, 2'h0);
        for (int i = 0; i < 14; i++)
        begin
            bus_write(11'h068, 32'h1 << i, 4'hf, 2'h0);
            bus_read(11'h068, 32'h3fff, 32'h1 << i, 2'h0);
        end
        @(negedge clk);
        check({31'h0, macro_clock}, 32'h0);
        @(posedge clk);
    endtask

    task automatic t_interrupt;
        alarm_sources[2] <= 1'b1;
        repeat (6) @(posedge clk);
        bus_read(11'h060, 32'h3fff, 32'h4, 2'h0);
        bus_write(11'h068, 32'h4, 4'hf, 2'h0);
        check_irq(1'b0);
        bus_write(11'h05c, 32'h8000_0000, 4'hf, 2'h0);
        check_irq(1'b1);
        bus_write(11'h068, 32'h0, 4'hf, 2'h0);
        check_irq(1'b0);
        bus_write(11'h060, 32'h4, 4'hf, 2'h0);
        bus_read(11'h060, 32'h3fff, 32'h0, 2'h0);
        alarm_sources[2] <= 1'b0;
        alarm_sources[1:0] <= 2'h3;
        repeat (6) @(posedge clk);
        bus_write(11'h060, 32'h3, 4'hf, 2'h0);
        alarm_sources[1:0] <= 2'h0;
        repeat (6) @(posedge clk);
        bus_read(11'h060, 32'h303, 32'h300, 2'h0);
        bus_write(11'h060, 32'h300, 4'hf, 2'h0);
    endtask

    task automatic t_macro;
        debug_port_wrote <= 1'b1;
        delay <= 2'h3;
        repeat (6) @(posedge clk);
        bus_write(11'h214, 32'h1234_fff0, 4'hf, 2'h0);
        check({16'h0, model.mem[5]}, 32'hfff0);
        delay <= 2'h0;
        bus_read(11'h214, 32'hfffe_ffff, 32'hfff0, 2'h0);
        bus_read(11'h214, 32'h0003_0000, 32'h0, 2'h0);
        debug_port_wrote <= 1'b0;
        bus_write(11'h214, 32'h1111, 4'h3, 2'h2);
        debug_port_wrote <= 1'b1;
        debug_port_lock <= 1'b1;
        repeat (6) @(posedge clk);
        bus_write(11'h214, 32'h2222, 4'hf, 2'h2);
        bus_read(11'h214, 32'h0003_0000, 32'h0003_0000, 2'h2);
        check({16'h0, model.mem[5]}, 32'hfff0);
        debug_port_lock <= 1'b0;
        repeat (6) @(posedge clk);
        bus_read(11'h214, 32'h0003_ffff, 32'h0001_fff0, 2'h0);
        bus_read(11'h214, 32'h0003_ffff, 32'h0000_fff0, 2'h0);
    endtask

    task automatic t_soft_reset;
        int p;
        bus_write(11'h068, 32'h3fff, 4'hf, 2'h0);
        bus_write(11'h100, 32'hffff_ffff, 4'hf, 2'h0);
        bus_read(11'h100, 32'hffff_ffff, 32'h0, 2'h0);
        p = pulses;
        bus_write(11'h000, 32'ha, 4'hf, 2'h0);
        repeat (3) @(posedge clk);
        check(32'(pulses - p), 32'h1);
        bus_read(11'h068, 32'h3fff, 32'h0, 2'h0);
        bus_read(11'h05c, 32'h8000_0000, 32'h0, 2'h0);
    endtask

    // ==========================================================
    // Run control
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the tests need a few hundred cycles.
    initial
    begin
        #100000;
        fails++;
        end_of_test();
    end

    // Reset, then the scenarios in turn.
    initial
    begin
        {clk, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = '0;
        {debug_port_wrote, debug_port_lock, alarm_sources, delay} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {fails, check_count} = '0;
        s_axi_bready = 1'b1;
        reset = 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_enables();
        t_interrupt();
        t_macro();
        t_soft_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
